// *** core/timer_params.svh ***
// address indices, bus widths, reset values and codes for the interval timer
`ifndef TIMER_PARAMS_SVH
`define TIMER_PARAMS_SVH

// bus geometry: byte address = 4 * register index
`define ADDR_W      18
`define IDX_W       16
`define DATA_W      32

// register indices (word index, byte address is four times this)
`define CTL0_IDX    16'hF360
`define CTLB_IDX    16'hF366
`define START_IDX   16'hF370
`define STOP_IDX    16'hF372
`define STAT_IDX    16'hF374
`define CNT0_IDX    16'hF378
`define MATCH0_IDX  16'hF380
`define IRQ_STAT_IDX 16'hF388
`define IRQ_EN_IDX  16'hF38A
`define IRQ_CLR_IDX 16'hF38C
`define IDX_STEP    16'h0002

// reset values and masks
`define CTL_RESET   8'h00
`define CTL_WMASK   8'hFB
`define MATCH_RESET 16'hFFFF
`define COUNT_ZERO  16'h0000
`define BITS_RESET  4'h0

// source select and prescale codes
`define SRC_LOW     2'h0
`define SRC_OSC     2'h1
`define SRC_EXT     2'h3
`define DIV_RSVD    3'h7
`define PRE_W       7
`define PRE_ONE     7'h01

// bus answers
`define RESP_OKAY   2'h0
`define RESP_SLVERR 2'h2

`endif

// *** core/timer_pkg.sv ***
// shared types of the interval timer
package timer_pkg;

	// one channel control byte, laid out as software sees it
	typedef struct packed {
		logic       single_shot;   // 1 = stop after one period
		logic       out_polarity;  // 1 = inverted wave
		logic [2:0] prescale_sel;  // divide by 2^code, code 7 divides by one
		logic       rsvd;          // reads zero
		logic [1:0] source_sel;    // count clock source
	} chan_ctrl_s;

	// per-channel run state
	typedef enum logic [1:0] {
		CH_IDLE,
		CH_ARM,
		CH_COUNT,
		CH_HALT
	} chan_state_e;

endpackage

// *** core/timer_channel.sv ***
// one 16-bit up-counting interval channel driven by a count tick
`include "timer_params.svh"
module timer_channel
	import timer_pkg::*;
#(
	parameter int W = 16
) (
	input  wire logic         aclk,
	input  wire logic         aresetn,
	input  wire logic         tick,
	input  wire logic         start,
	input  wire logic         stop,
	input  wire logic         zero_count,
	input  wire logic         single_shot,
	input  wire logic         out_polarity,
	input  wire logic [W-1:0] chan_match_value,
	output logic      [W-1:0] chan_count_value,
	output logic              counting,
	output logic              match_pulse,
	output logic              wave_out
);

	chan_state_e  state_r;   // run state
	logic [W-1:0] count_r;   // live count
	logic         toggle_r;  // wave before polarity
	logic         hit;       // count equals match value
	logic         stepping;  // counter advances this cycle

	assign hit      = (count_r == chan_match_value);
	assign stepping = tick && ((state_r == CH_COUNT) || (state_r == CH_HALT));
	assign counting = (state_r != CH_IDLE);
	assign chan_count_value = count_r;

	////////////////////////////////////////////////////////////////////////
	// run state: arm waits for the first tick so starting is synchronous
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= CH_IDLE;
		end else begin
			unique case (state_r)
				CH_IDLE: begin
					// stop is ignored here
					if (start) begin
						state_r <= CH_ARM;
					end
				end
				CH_ARM: begin
					if (stop) begin
						state_r <= CH_HALT;
					end else if (tick) begin
						state_r <= CH_COUNT;
					end
				end
				CH_COUNT: begin
					if (stop) begin
						state_r <= CH_HALT;
					end else if (tick && hit && single_shot) begin
						state_r <= CH_IDLE;
					end
				end
				CH_HALT: begin
					// a fresh start cancels the pending halt
					if (start) begin
						state_r <= CH_COUNT;
					end else if (tick) begin
						state_r <= CH_IDLE;
					end
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// counter: software clear beats a tick in the same cycle
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			count_r <= `COUNT_ZERO;
		end else if (zero_count) begin
			count_r <= `COUNT_ZERO;
		end else if (stepping) begin
			// reload on match, never cleared by stop or restart
			count_r <= hit ? `COUNT_ZERO : count_r + W'(1);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// match pulse and output wave
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			match_pulse <= 1'b0;
			toggle_r    <= 1'b0;
			wave_out    <= 1'b0;
		end else begin
			match_pulse <= stepping && hit;
			if (stepping && hit) begin
				toggle_r <= ~toggle_r;
			end
			wave_out <= toggle_r ^ out_polarity;
		end
	end

endmodule

// *** core/quad_sixteen_bit_interval_timer.sv ***
// four 16-bit interval timers behind an AXI4-Lite slave
`include "timer_params.svh"
module quad_sixteen_bit_interval_timer
	import timer_pkg::*;
#(
	parameter int CHANNELS = 4,
	parameter int CNT_W    = 16
) (
	input  wire logic                 aclk,
	input  wire logic                 aresetn,
	// write address channel
	input  wire logic [`ADDR_W-1:0]   s_axi_awaddr,
	input  wire logic [2:0]           s_axi_awprot,
	input  wire logic                 s_axi_awvalid,
	output logic                      s_axi_awready,
	// write data channel
	input  wire logic [`DATA_W-1:0]   s_axi_wdata,
	input  wire logic [`DATA_W/8-1:0] s_axi_wstrb,
	input  wire logic                 s_axi_wvalid,
	output logic                      s_axi_wready,
	// write response channel
	output logic [1:0]                s_axi_bresp,
	output logic                      s_axi_bvalid,
	input  wire logic                 s_axi_bready,
	// read address channel
	input  wire logic [`ADDR_W-1:0]   s_axi_araddr,
	input  wire logic [2:0]           s_axi_arprot,
	input  wire logic                 s_axi_arvalid,
	output logic                      s_axi_arready,
	// read data channel
	output logic [`DATA_W-1:0]        s_axi_rdata,
	output logic [1:0]                s_axi_rresp,
	output logic                      s_axi_rvalid,
	input  wire logic                 s_axi_rready,
	// count clock sources, all asynchronous to aclk
	input  wire logic                 low_speed_clock,
	input  wire logic                 oscillator_clock,
	input  wire logic                 ext_clock_pin,
	// outputs
	output logic [CHANNELS-1:0]       chan_wave_out,
	output logic [CHANNELS-1:0]       chan_match_irq,
	output logic                      irq
);

	////////////////////////////////////////////////////////////////////////
	// declarations

	localparam int SRCS = 3; // low, oscillator, external

	// source synchronisers: three stages, stage one feeds stage two only
	logic [SRCS-1:0]     src_in;      // raw source levels
	logic [SRCS-1:0]     sync1_r;     // metastability stage
	logic [SRCS-1:0]     sync2_r;     // second stage
	logic [SRCS-1:0]     sync3_r;     // third stage
	logic [SRCS-1:0]     level_r;     // accepted level
	logic [SRCS-1:0]     agree;       // stages two and three agree
	logic [SRCS-1:0]     src_fall;    // accepted falling edge, one cycle

	// configuration and per-channel state
	chan_ctrl_s          ctrl_r   [CHANNELS]; // control bytes
	logic [CNT_W-1:0]    match_r  [CHANNELS]; // match values
	logic [CNT_W-1:0]    count    [CHANNELS]; // live counts
	logic [`PRE_W-1:0]   pre_cnt_r[CHANNELS]; // prescale counters
	logic [CHANNELS-1:0] tick;        // divided falling edge
	logic [CHANNELS-1:0] running;     // counting status
	logic [CHANNELS-1:0] match_pls;   // match events
	logic [CHANNELS-1:0] start_pls;   // start requests
	logic [CHANNELS-1:0] stop_pls;    // stop requests
	logic [CHANNELS-1:0] zero_pls;    // counter clears

	// interrupt registers
	logic [CHANNELS-1:0] irq_stat_r;  // sticky match flags
	logic [CHANNELS-1:0] irq_en_r;    // enables
	logic [CHANNELS-1:0] irq_clr;     // clear strobes this cycle

	// write path holding registers
	logic                aw_held_r;
	logic [`IDX_W-1:0]   aw_idx_r;
	logic                w_held_r;
	logic [`DATA_W-1:0]  w_data_r;
	logic [`DATA_W/8-1:0] w_strb_r;
	logic                wr_fire;     // both halves present
	logic                wr_hit;      // index is mapped
	logic [`IDX_W-1:0]   ar_idx;      // read index
	logic [`DATA_W-1:0]  rd_data;     // read mux output
	logic                rd_hit;      // read index is mapped

	////////////////////////////////////////////////////////////////////////
	// clock source crossing into aclk
	assign src_in = {ext_clock_pin, oscillator_clock, low_speed_clock};
	assign agree  = ~(sync2_r ^ sync3_r);
	assign src_fall = level_r & agree & ~sync3_r;

	// a change is accepted only once stages two and three agree
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_r <= '0;
			sync2_r <= '0;
			sync3_r <= '0;
			level_r <= '0;
		end else begin
			sync1_r <= src_in;
			sync2_r <= sync1_r;
			sync3_r <= sync2_r;
			level_r <= (agree & sync3_r) | (~agree & level_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// divide-by mask for a prescale code; the reserved code passes through
	function automatic logic [`PRE_W-1:0] pre_mask(input logic [2:0] code);
		logic [`PRE_W-1:0] m;
		m = '0;
		if (code != `DIV_RSVD) begin
			m = `PRE_W'((`PRE_ONE << code) - `PRE_ONE);
		end
		return m;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// per-channel clock selection, prescaler and counter core
	generate
		for (genvar i = 0; i < CHANNELS; i++) begin : g_chan
			logic              sel_fall; // falling edge of chosen source
			logic [`PRE_W-1:0] mask;     // prescale mask

			// source select, reserved code falls back to low speed
			always_comb begin
				unique case (ctrl_r[i].source_sel)
					`SRC_OSC: sel_fall = src_fall[1];
					`SRC_EXT: sel_fall = src_fall[2];
					default:  sel_fall = src_fall[0];
				endcase
			end

			assign mask    = pre_mask(ctrl_r[i].prescale_sel);
			// divided clock falls once per 2^code source falls, on every source fall for code 7
			assign tick[i] = sel_fall && ((pre_cnt_r[i] & mask) == mask);

			// prescaler restarts while stopped so each start is repeatable
			always_ff @(posedge aclk) begin
				if (!aresetn) begin
					pre_cnt_r[i] <= '0;
				end else if (!running[i]) begin
					pre_cnt_r[i] <= '0;
				end else if (sel_fall) begin
					pre_cnt_r[i] <= pre_cnt_r[i] + `PRE_W'(1);
				end
			end

			timer_channel #(
				.W(CNT_W)
			) u_chan (
				.aclk            (aclk),
				.aresetn         (aresetn),
				.tick            (tick[i]),
				.start           (start_pls[i]),
				.stop            (stop_pls[i]),
				.zero_count      (zero_pls[i]),
				.single_shot     (ctrl_r[i].single_shot),
				.out_polarity    (ctrl_r[i].out_polarity),
				.chan_match_value(match_r[i]),
				.chan_count_value(count[i]),
				.counting        (running[i]),
				.match_pulse     (match_pls[i]),
				.wave_out        (chan_wave_out[i])
			);
		end
	endgenerate

	assign chan_match_irq = match_pls;

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite write: address and data taken in either order
	assign s_axi_awready = !aw_held_r;
	assign s_axi_wready  = !w_held_r;
	assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;

	// hold the address until the write is carried out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held_r <= 1'b0;
			aw_idx_r  <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			aw_held_r <= 1'b1;
			aw_idx_r  <= s_axi_awaddr[`ADDR_W-1:2];
		end else if (wr_fire) begin
			aw_held_r <= 1'b0;
		end
	end

	// hold the data until the write is carried out
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held_r <= 1'b0;
			w_data_r <= '0;
			w_strb_r <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			w_held_r <= 1'b1;
			w_data_r <= s_axi_wdata;
			w_strb_r <= s_axi_wstrb;
		end else if (wr_fire) begin
			w_held_r <= 1'b0;
		end
	end

	// mapped write indices
	always_comb begin
		wr_hit = (aw_idx_r == `START_IDX) || (aw_idx_r == `STOP_IDX) || (aw_idx_r == `STAT_IDX)
			|| (aw_idx_r == `IRQ_STAT_IDX) || (aw_idx_r == `IRQ_EN_IDX) || (aw_idx_r == `IRQ_CLR_IDX);
		for (int i = 0; i < CHANNELS; i++) begin
			if ((aw_idx_r == `CTL0_IDX + `IDX_W'(i) * `IDX_STEP)
				|| (aw_idx_r == `CNT0_IDX + `IDX_W'(i) * `IDX_STEP)
				|| (aw_idx_r == `MATCH0_IDX + `IDX_W'(i) * `IDX_STEP)) begin
				wr_hit = 1'b1;
			end
		end
	end

	// response: unmapped index answers slave error, nothing stored
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= `RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// write strobes into the channels: one-cycle pulses
	always_comb begin
		for (int i = 0; i < CHANNELS; i++) begin
			start_pls[i] = wr_fire && w_strb_r[0] && (aw_idx_r == `START_IDX) && w_data_r[i];
			stop_pls[i]  = wr_fire && w_strb_r[0] && (aw_idx_r == `STOP_IDX) && w_data_r[i];
			// any lane, any value: the data are discarded
			zero_pls[i]  = wr_fire && (|w_strb_r)
				&& (aw_idx_r == `CNT0_IDX + `IDX_W'(i) * `IDX_STEP);
			irq_clr[i]   = wr_fire && w_strb_r[0] && (aw_idx_r == `IRQ_CLR_IDX) && w_data_r[i];
		end
	end

	// control bytes; software must only rewrite a stopped channel,
	// a write while running takes effect at once and may glitch the period
	always_ff @(posedge aclk) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (!aresetn) begin
				ctrl_r[i] <= chan_ctrl_s'(`CTL_RESET);
			end else if (wr_fire && w_strb_r[0] && (aw_idx_r == `CTL0_IDX + `IDX_W'(i) * `IDX_STEP)) begin
				ctrl_r[i] <= chan_ctrl_s'(w_data_r[7:0] & `CTL_WMASK);
			end
		end
	end

	// match values, byte lanes honoured
	always_ff @(posedge aclk) begin
		for (int i = 0; i < CHANNELS; i++) begin
			if (!aresetn) begin
				match_r[i] <= `MATCH_RESET;
			end else if (wr_fire && (aw_idx_r == `MATCH0_IDX + `IDX_W'(i) * `IDX_STEP)) begin
				if (w_strb_r[0]) begin
					match_r[i][7:0] <= w_data_r[7:0];
				end
				if (w_strb_r[1]) begin
					match_r[i][15:8] <= w_data_r[15:8];
				end
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupts: a match in the clearing cycle survives the clear
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_stat_r <= `BITS_RESET;
		end else begin
			irq_stat_r <= (irq_stat_r & ~irq_clr) | match_pls;
		end
	end

	// enable register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq_en_r <= `BITS_RESET;
		end else if (wr_fire && w_strb_r[0] && (aw_idx_r == `IRQ_EN_IDX)) begin
			irq_en_r <= w_data_r[CHANNELS-1:0];
		end
	end

	// level interrupt, registered
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			irq <= 1'b0;
		end else begin
			irq <= |(irq_stat_r & irq_en_r);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// AXI4-Lite read: one outstanding read, answer one cycle after taking
	assign s_axi_arready = !s_axi_rvalid;
	assign ar_idx        = s_axi_araddr[`ADDR_W-1:2];

	// read mux; write-only registers read zero
	always_comb begin
		rd_data = '0;
		rd_hit  = 1'b1;
		if ((ar_idx == `START_IDX) || (ar_idx == `STOP_IDX) || (ar_idx == `IRQ_CLR_IDX)) begin
			rd_data = '0;
		end else if (ar_idx == `STAT_IDX) begin
			rd_data[CHANNELS-1:0] = running;
		end else if (ar_idx == `IRQ_STAT_IDX) begin
			rd_data[CHANNELS-1:0] = irq_stat_r;
		end else if (ar_idx == `IRQ_EN_IDX) begin
			rd_data[CHANNELS-1:0] = irq_en_r;
		end else begin
			rd_hit = 1'b0;
			for (int i = 0; i < CHANNELS; i++) begin
				if (ar_idx == `CTL0_IDX + `IDX_W'(i) * `IDX_STEP) begin
					rd_data[7:0] = ctrl_r[i];
					rd_hit       = 1'b1;
				end
				if (ar_idx == `CNT0_IDX + `IDX_W'(i) * `IDX_STEP) begin
					// same clock domain, so a running count reads coherently
					rd_data[CNT_W-1:0] = count[i];
					rd_hit             = 1'b1;
				end
				if (ar_idx == `MATCH0_IDX + `IDX_W'(i) * `IDX_STEP) begin
					rd_data[CNT_W-1:0] = match_r[i];
					rd_hit             = 1'b1;
				end
			end
		end
	end

	// read data register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= '0;
			s_axi_rresp  <= `RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_data;
			s_axi_rresp  <= rd_hit ? `RESP_OKAY : `RESP_SLVERR;
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end

endmodule

// *** verif/timer_bus_checker.sv ***
// concurrent checks on the timer's bus handshakes and event outputs
`include "timer_params.svh"
module timer_bus_checker
	import timer_pkg::*;
#(
	parameter int CHANNELS = 4
) (
	input wire logic                aclk,
	input wire logic                aresetn,
	input wire logic                s_axi_awvalid,
	input wire logic                s_axi_awready,
	input wire logic                s_axi_wvalid,
	input wire logic                s_axi_wready,
	input wire logic [1:0]          s_axi_bresp,
	input wire logic                s_axi_bvalid,
	input wire logic                s_axi_bready,
	input wire logic                s_axi_arvalid,
	input wire logic                s_axi_arready,
	input wire logic [`DATA_W-1:0]  s_axi_rdata,
	input wire logic [1:0]          s_axi_rresp,
	input wire logic                s_axi_rvalid,
	input wire logic                s_axi_rready,
	input wire logic [CHANNELS-1:0] chan_match_irq,
	input wire logic                irq
);
	timeunit 1ns;
	timeprecision 1ps;
	// one clock domain: shared clock and reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	////////////////////////////////////////////////////////////////////////////////
	// bus answers stand until taken
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
	a_bhold: assert property (p_bhold) else $error("write response dropped early");
	property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
	a_rhold: assert property (p_rhold) else $error("read data dropped early");
	// read answers one cycle after its address, write two after both halves
	property p_rlat; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rlat: assert property (p_rlat) else $error("read answer late");
	property p_blat; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid; endproperty
	a_blat: assert property (p_blat) else $error("write answer late");
	// address held blocks a second address until the write is carried out
	property p_awhold; s_axi_awvalid && s_axi_awready && !s_axi_wvalid |=> !s_axi_awready; endproperty
	a_awhold: assert property (p_awhold) else $error("second write address taken");
	property p_arblock; s_axi_rvalid |-> !s_axi_arready; endproperty
	a_arblock: assert property (p_arblock) else $error("read address taken while answer pending");
	// refused accesses carry zero data and a legal code
	property p_slverr; s_axi_rvalid && s_axi_rresp == `RESP_SLVERR |-> s_axi_rdata == 32'h0000_0000; endproperty
	a_slverr: assert property (p_slverr) else $error("refused read carries data");
	property p_bcode; s_axi_bvalid |-> s_axi_bresp == `RESP_OKAY || s_axi_bresp == `RESP_SLVERR; endproperty
	a_bcode: assert property (p_bcode) else $error("illegal write response code");
	// a match event is a single-cycle pulse
	property p_pulse; |chan_match_irq |=> (chan_match_irq & $past(chan_match_irq)) == '0; endproperty
	a_pulse: assert property (p_pulse) else $error("match pulse longer than one cycle");
	////////////////////////////////////////////////////////////////////////////////
	// main scenarios seen
	c_match: cover property (|chan_match_irq);
	c_irq: cover property ($rose(irq));
	c_slverr: cover property (s_axi_rvalid && s_axi_rresp == `RESP_SLVERR);
endmodule

// *** verif/test_quad_sixteen_bit_interval_timer.sv ***
// self-checking bench for the quad interval timer
`include "timer_params.svh"
module test_quad_sixteen_bit_interval_timer
	import timer_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int CHANNELS = 4;
	logic aclk = 1'b0, aresetn = 1'b0;
	logic [`ADDR_W-1:0] s_axi_awaddr = '0, s_axi_araddr = '0;
	logic [2:0] s_axi_awprot = 3'h0, s_axi_arprot = 3'h0;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, irq;
	logic [`DATA_W-1:0] s_axi_wdata = '0, s_axi_rdata;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic low_speed_clock = 1'b0, oscillator_clock = 1'b0, ext_clock_pin = 1'b0;
	logic [CHANNELS-1:0] chan_wave_out, chan_match_irq;
	int cyc = 0;        // cycle stamp for period measurement
	int err_count = 0;  // mismatches
	int num_checks = 0; // comparisons
	quad_sixteen_bit_interval_timer #(.CHANNELS(CHANNELS), .CNT_W(16)) dut_u (.aclk, .aresetn, .s_axi_awaddr,
		.s_axi_awprot, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
		.s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .low_speed_clock, .oscillator_clock,
		.ext_clock_pin, .chan_wave_out, .chan_match_irq, .irq);
	////////////////////////////////////////////////////////////////////////////////
	// clock and three count sources of different rates, so a wrong source shows
	always #10 aclk = ~aclk;
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		low_speed_clock <= (cyc % 8) < 4;
		oscillator_clock <= (cyc % 6) < 3;
		ext_clock_pin <= (cyc % 10) < 5;
	end
	////////////////////////////////////////////////////////////////////////////////
	// comparison and bus tasks
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	function automatic logic [15:0] ix(input logic [15:0] base, input int ch);
		return base + 16'(ch) * `IDX_STEP;
	endfunction
	// address and data offered together, response accepted when it comes
	task automatic axi_wr(input logic [15:0] idx, input logic [31:0] d, input logic [3:0] strb, output logic [1:0] r);
		bit aw_p = 1, w_p = 1, done = 0;
		@(posedge aclk);
		s_axi_awaddr <= {idx, 2'b00}; s_axi_awvalid <= 1'b1;
		s_axi_wdata <= d; s_axi_wstrb <= strb; s_axi_wvalid <= 1'b1; s_axi_bready <= 1'b1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(posedge aclk);
			if (aw_p && s_axi_awready) begin aw_p = 0; s_axi_awvalid <= 1'b0; end
			if (w_p && s_axi_wready) begin w_p = 0; s_axi_wvalid <= 1'b0; end
			if (s_axi_bvalid === 1'b1) begin done = 1; r = s_axi_bresp; s_axi_bready <= 1'b0; end
		end
		if (!done) check("write answer", 1, 0);
	endtask
	task automatic axi_rd(input logic [15:0] idx, output logic [31:0] d, output logic [1:0] r);
		bit ar_p = 1, done = 0;
		@(posedge aclk);
		s_axi_araddr <= {idx, 2'b00}; s_axi_arvalid <= 1'b1; s_axi_rready <= 1'b1;
		for (int n = 0; n < 100 && !done; n++) begin
			@(posedge aclk);
			if (ar_p && s_axi_arready) begin ar_p = 0; s_axi_arvalid <= 1'b0; end
			if (s_axi_rvalid === 1'b1) begin done = 1; d = s_axi_rdata; r = s_axi_rresp; s_axi_rready <= 1'b0; end
		end
		if (!done) check("read answer", 1, 0);
	endtask
	task automatic wr(input logic [15:0] idx, input logic [31:0] d);
		logic [1:0] r;
		axi_wr(idx, d, 4'hF, r);
	endtask
	task automatic rd_chk(input string what, input logic [15:0] idx, input logic [31:0] exp);
		logic [31:0] d; logic [1:0] r;
		axi_rd(idx, d, r);
		check(what, exp, d);
	endtask
	// poll until the channel's status bit drops
	task automatic stop_wait(input int ch);
		logic [31:0] d; logic [1:0] r;
		for (int n = 0; n < 1000; n++) begin axi_rd(`STAT_IDX, d, r); if (d[ch] === 1'b0) break; end
		check("stopped", 0, d[ch]);
	endtask
	task automatic wait_pulse(input int ch, output int t);
		bit hit = 0;
		for (int n = 0; n < 5000 && !hit; n++) begin @(posedge aclk); hit = chan_match_irq[ch] === 1'b1; end
		t = cyc;
		check("match pulse seen", 1, hit);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// reset values, refused addresses, start 0 and stop while stopped
	task automatic t_reset();
		logic [31:0] d; logic [1:0] r;
		for (int ch = 0; ch < 4; ch++) begin
			rd_chk("ctrl", ix(`CTL0_IDX, ch), 32'h0);
			rd_chk("match", ix(`MATCH0_IDX, ch), 32'hFFFF);
			rd_chk("count", ix(`CNT0_IDX, ch), 32'h0);
		end
		rd_chk("irq status", `IRQ_STAT_IDX, 32'h0);
		check("wave", 0, chan_wave_out);
		axi_rd(16'h0100, d, r);
		check("unmapped resp", `RESP_SLVERR, r);
		check("unmapped data", 0, d);
		axi_wr(16'h0100, 32'h5, 4'hF, r);
		check("unmapped wr resp", `RESP_SLVERR, r);
		wr(`STOP_IDX, 32'hF);
		wr(`START_IDX, 32'h0);
		rd_chk("status", `STAT_IDX, 32'h0);
		wr(ix(`CTL0_IDX, 2), 32'hFF);
		rd_chk("ctrl mask", ix(`CTL0_IDX, 2), 32'hFB);
		wr(ix(`CTL0_IDX, 2), 32'h0);
		$display("test reset done");
	endtask
	// every source and prescale code, period between the second and third match
	task automatic t_sources();
		logic [7:0] cv [11] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38};
		int pv [11] = '{32, 24, 32, 40, 64, 128, 256, 512, 1024, 2048, 32};
		int t0, t1;
		for (int i = 0; i < 11; i++) begin
			wr(ix(`CTL0_IDX, 1), 32'h0);
			wr(ix(`CTL0_IDX, 1), {24'h0, cv[i]});
			wr(ix(`MATCH0_IDX, 1), 32'h3);
			wr(`START_IDX, 32'h2);
			wait_pulse(1, t0);
			wait_pulse(1, t0);
			wait_pulse(1, t1);
			check("period", pv[i], t1 - t0);
			wr(`STOP_IDX, 32'h2);
			stop_wait(1);
		end
		$display("test sources done");
	endtask
	// one more tick after stop, resume from held count, counter write clears
	task automatic t_stop_resume();
		logic [31:0] c0, d; logic [1:0] r;
		wr(`CTL0_IDX, 32'h0);
		wr(`CTL0_IDX, 32'h30);
		wr(`START_IDX, 32'h1);
		for (int n = 0; n < 2000; n++) begin
			axi_rd(`CNT0_IDX, c0, r);
			axi_rd(`CNT0_IDX, d, r);
			if (c0 !== 32'h0 && d === c0) break;
		end
		wr(`STOP_IDX, 32'h1);
		rd_chk("status after stop", `STAT_IDX, 32'h1);
		stop_wait(0);
		rd_chk("count after stop", `CNT0_IDX, c0 + 1);
		repeat (600) @(posedge aclk);
		rd_chk("count held", `CNT0_IDX, c0 + 1);
		wr(`START_IDX, 32'h1);
		for (int n = 0; n < 2000; n++) begin axi_rd(`CNT0_IDX, d, r); if (d !== c0 + 1) break; end
		check("resumed count", c0 + 2, d);
		axi_wr(`CNT0_IDX, 32'h1234, 4'h2, r);
		rd_chk("count cleared", `CNT0_IDX, 32'h0);
		wr(`STOP_IDX, 32'h1);
		stop_wait(0);
		$display("test stop resume done");
	endtask
	// one-shot with inverted wave, then interrupt enable, mask and clear
	task automatic t_irq();
		int t;
		wr(`IRQ_CLR_IDX, 32'hF);
		wr(ix(`CTL0_IDX, 3), 32'h0);
		wr(ix(`CTL0_IDX, 3), 32'hC0);
		repeat (2) @(posedge aclk);
		check("inverted wave", 1, chan_wave_out[3]);
		wr(ix(`MATCH0_IDX, 3), 32'h2);
		wr(`IRQ_EN_IDX, 32'h8);
		wr(`START_IDX, 32'h8);
		wait_pulse(3, t);
		repeat (3) @(posedge aclk);
		check("irq on", 1, irq);
		check("wave toggled", 0, chan_wave_out[3]);
		rd_chk("one shot status", `STAT_IDX, 32'h0);
		rd_chk("reloaded count", ix(`CNT0_IDX, 3), 32'h0);
		rd_chk("irq status", `IRQ_STAT_IDX, 32'h8);
		wr(`IRQ_EN_IDX, 32'h0);
		repeat (2) @(posedge aclk);
		check("irq masked", 0, irq);
		wr(`IRQ_EN_IDX, 32'h8);
		repeat (2) @(posedge aclk);
		check("irq unmasked", 1, irq);
		wr(`IRQ_CLR_IDX, 32'h8);
		repeat (2) @(posedge aclk);
		check("irq cleared", 0, irq);
		rd_chk("irq status clear", `IRQ_STAT_IDX, 32'h0);
		$display("test irq done");
	endtask
	////////////////////////////////////////////////////////////////////////////////
	// verdict
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", num_checks, err_count);
		if (err_count == 0 && num_checks > 0) $display("Result: passed");
		else $display("Result: failed");
		$finish;
	endtask
	// watchdog well above the expected run of some 20k cycles
	initial begin
		#2_000_000;
		err_count++;
		end_of_test();
	end
	initial begin
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_sources();
		t_stop_resume();
		t_irq();
		end_of_test();
	end
endmodule
bind quad_sixteen_bit_interval_timer timer_bus_checker #(.CHANNELS(CHANNELS)) chk_u (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .chan_match_irq, .irq);
